/* File: rtl/tcpio_consts.vh */
// Constants for the timer channel pin control block.
`ifndef TCPIO_CONSTS_VH
`define TCPIO_CONSTS_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TCPIO_OFF_OUT_LEVEL 12'h000
`define TCPIO_OFF_OUT_ENABLE 12'h004
`define TCPIO_OFF_OUT_MODE 12'h008
`define TCPIO_OFF_OUT_POLARITY 12'h00c
`define TCPIO_OFF_START 12'h010
`define TCPIO_OFF_RUNNING 12'h014
`define TCPIO_OFF_START_IRQ 12'h018
`define TCPIO_OFF_FILTER 12'h01c
`define TCPIO_OFF_CHAN_MODE 12'h020
`define TCPIO_OFF_IN_STATE 12'h024
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define TCPIO_CMODE_INTERVAL 2'h0
`define TCPIO_CMODE_CAPTURE 2'h1
`define TCPIO_CMODE_OTHER 2'h2
`define TCPIO_RST_OUT_LEVEL 4'h0
`define TCPIO_RST_FIELD 4'h0
`define TCPIO_CMODE_BITS 2
`endif

/* File: rtl/tcpio_top.v */
// Timer channel output and input pin control with an AHB-Lite register slave.
// Notes on behaviour
// - Output mode bit: 0 master toggle output, 1 slave set/reset output.
// - Level bit: 0 positive logic, 1 negative logic output.
// - Output enable 1 makes software writes to that output bit void.
// - Output settings never disturb the counter side.
// - Master mode ignores level and toggles on every toggle event.
// - Slave mode takes the active level from the level bit.
// - Level change in slave mode acts only at next set or reset.
// - Slave set from master interrupt is delayed one count clock.
// - Simultaneous set and reset: reset wins, set discarded.
// - Output register: one bit per channel, writes only where enable 0.
// - Enabled outputs ignore writes but keep timer-driven changes.
// - Interval or capture with start-irq 1: interrupt at start, and toggle at start in master mode.
// - Start-irq 0: no interrupt, no toggle at count start.
// - Other modes: start-irq bit controls nothing at start.
// - Input passes noise filter then edge detector.
// - Filter off: input only synchronised.
// - Filter on: level accepted after three agreeing synchronised samples.
// - Slave level 0: master sets, slave resets; level 1 swaps.
// - Enable 0: interrupts do not touch the output bit.
// - Output register reads back the pin levels at any time.
// - Filter adds two clocks of edge detection latency.
`timescale 1ns/1ps
`include "tcpio_consts.vh"
module tcpio_top #(
  parameter NCH = 4
) (
  // Clock and reset.
  input wire clk,
  input wire nrst,
  // AHB-Lite slave.
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Timer event inputs from the counter logic, one pulse per count clock.
  input wire [NCH-1:0] master_chan_irq,
  input wire [NCH-1:0] slave_chan_irq,
  input wire [NCH-1:0] count_start,
  // Timer input pins and their conditioned outputs.
  input wire [NCH-1:0] timer_in_pin,
  output reg [NCH-1:0] in_level,
  output reg [NCH-1:0] in_rise,
  output reg [NCH-1:0] in_fall,
  // Outputs toward the counter and pins.
  output reg [NCH-1:0] start_irq,
  output reg [NCH-1:0] chan_start_strobe,
  output reg [NCH-1:0] chan_running_flag,
  output reg [NCH-1:0] timer_out_pin
);
  localparam CW = `TCPIO_CMODE_BITS;
  // ****************************************************************
  // Register state
  // ****************************************************************
  reg [NCH-1:0] out_level_reg;
  reg [NCH-1:0] out_enable_reg;
  reg [NCH-1:0] out_mode_reg;
  reg [NCH-1:0] out_polarity_reg;
  reg [NCH-1:0] start_irq_reg;
  reg [NCH-1:0] filter_reg;
  reg [NCH*CW-1:0] chan_mode_reg;
  reg [NCH-1:0] set_dly_reg;
  reg [NCH-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, prev_reg;
  reg [NCH-1:0] filt2_reg;
  reg [NCH-1:0] out_level_next;
  reg ph_valid_reg;
  reg ph_write_reg;
  reg [11:0] ph_addr_reg;
  reg [NCH-1:0] wdata;
  wire wr_en;
  integer i;

  function is_start_mode;
    input [CW-1:0] m;
    begin
      is_start_mode = (m == `TCPIO_CMODE_INTERVAL) ||
        (m == `TCPIO_CMODE_CAPTURE);
    end
  endfunction

  // ****************************************************************
  // Bus slave: zero wait states, always OKAY
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = ph_valid_reg & ph_write_reg;

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= 12'h000;
    end
    else if (hready)
    begin
      ph_valid_reg <= hsel & htrans[1];
      ph_write_reg <= hwrite;
      ph_addr_reg <= haddr;
    end
  end

  always @*
  begin
    wdata = hwdata[NCH-1:0];
  end

  // Read data is registered in the address phase so it stands in the data phase.
  always @(posedge clk)
  begin
    if (!nrst)
      hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      hrdata <= 32'h00000000;
      case (haddr)
        `TCPIO_OFF_OUT_LEVEL: hrdata[NCH-1:0] <= timer_out_pin;
        `TCPIO_OFF_OUT_ENABLE: hrdata[NCH-1:0] <= out_enable_reg;
        `TCPIO_OFF_OUT_MODE: hrdata[NCH-1:0] <= out_mode_reg;
        `TCPIO_OFF_OUT_POLARITY: hrdata[NCH-1:0] <= out_polarity_reg;
        `TCPIO_OFF_RUNNING: hrdata[NCH-1:0] <= chan_running_flag;
        `TCPIO_OFF_START_IRQ: hrdata[NCH-1:0] <= start_irq_reg;
        `TCPIO_OFF_FILTER: hrdata[NCH-1:0] <= filter_reg;
        `TCPIO_OFF_CHAN_MODE: hrdata[NCH*CW-1:0] <= chan_mode_reg;
        `TCPIO_OFF_IN_STATE: hrdata[NCH-1:0] <= in_level;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      out_enable_reg <= {NCH{1'b0}};
      out_mode_reg <= {NCH{1'b0}};
      out_polarity_reg <= {NCH{1'b0}};
      start_irq_reg <= {NCH{1'b0}};
      filter_reg <= {NCH{1'b0}};
      chan_mode_reg <= {NCH*CW{1'b0}};
      chan_start_strobe <= {NCH{1'b0}};
      chan_running_flag <= {NCH{1'b0}};
    end
    else
    begin
      // The start bit reads as zero; it only pulses one cycle.
      chan_start_strobe <= {NCH{1'b0}};
      if (wr_en)
      begin
        case (ph_addr_reg)
          `TCPIO_OFF_OUT_ENABLE: out_enable_reg <= wdata;
          `TCPIO_OFF_OUT_MODE: out_mode_reg <= wdata;
          `TCPIO_OFF_OUT_POLARITY: out_polarity_reg <= wdata;
          `TCPIO_OFF_START_IRQ: start_irq_reg <= wdata;
          `TCPIO_OFF_FILTER: filter_reg <= wdata;
          `TCPIO_OFF_CHAN_MODE: chan_mode_reg <= hwdata[NCH*CW-1:0];
          `TCPIO_OFF_START:
          begin
            chan_start_strobe <= wdata;
            chan_running_flag <= chan_running_flag | wdata;
          end
          // Writing ones to the running register stops those channels.
          `TCPIO_OFF_RUNNING:
            chan_running_flag <= chan_running_flag & ~wdata;
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // Output circuit
  // ****************************************************************
  // The output path only reads counter events and never feeds back into
  // them, so reconfiguring it while running cannot upset counting.
  always @*
  begin
    out_level_next = out_level_reg;
    for (i = 0; i < NCH; i = i + 1)
    begin
      if (wr_en && ph_addr_reg == `TCPIO_OFF_OUT_LEVEL &&
          !out_enable_reg[i])
        out_level_next[i] = wdata[i];
      else if (out_enable_reg[i])
      begin
        if (!out_mode_reg[i])
        begin
          // Polarity is not consulted in master mode.
          if (slave_chan_irq[i] ||
              (count_start[i] && start_irq_reg[i] &&
               is_start_mode(chan_mode_reg[i*CW +: CW])))
            out_level_next[i] = ~out_level_reg[i];
        end
        else
        begin
          // Set from master (delayed) and reset from slave, swapped by
          // polarity; only these events move the pin.
          if (slave_chan_irq[i])
            out_level_next[i] = out_polarity_reg[i];
          else if (set_dly_reg[i])
            out_level_next[i] = ~out_polarity_reg[i];
        end
      end
    end
  end

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      out_level_reg <= {NCH{1'b0}};
      timer_out_pin <= {NCH{1'b0}};
      set_dly_reg <= {NCH{1'b0}};
      start_irq <= {NCH{1'b0}};
    end
    else
    begin
      out_level_reg <= out_level_next;
      timer_out_pin <= out_level_next;
      set_dly_reg <= master_chan_irq;
      for (i = 0; i < NCH; i = i + 1)
        start_irq[i] <= count_start[i] & start_irq_reg[i] &
          is_start_mode(chan_mode_reg[i*CW +: CW]);
    end
  end

  // ****************************************************************
  // Input path
  // ****************************************************************
  // Three flops synchronise; filter on needs the second and third to agree
  // twice in a row, which costs two clocks more.
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      sync1_reg <= {NCH{1'b0}};
      sync2_reg <= {NCH{1'b0}};
      sync3_reg <= {NCH{1'b0}};
      filt_reg <= {NCH{1'b0}};
      filt2_reg <= {NCH{1'b0}};
      prev_reg <= {NCH{1'b0}};
      in_level <= {NCH{1'b0}};
      in_rise <= {NCH{1'b0}};
      in_fall <= {NCH{1'b0}};
    end
    else
    begin
      sync1_reg <= timer_in_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // A second filter stage gives the full two clocks of extra latency.
      filt2_reg <= filt_reg;
      for (i = 0; i < NCH; i = i + 1)
      begin
        if (sync2_reg[i] == sync3_reg[i])
          filt_reg[i] <= sync3_reg[i];
        if (!filter_reg[i])
          in_level[i] <= sync3_reg[i];
        else if (filt2_reg[i] == filt_reg[i] &&
                 filt_reg[i] == sync3_reg[i])
          in_level[i] <= filt2_reg[i];
      end
      prev_reg <= in_level;
      in_rise <= in_level & ~prev_reg;
      in_fall <= ~in_level & prev_reg;
    end
  end
endmodule

/* File: test/tcpio_checker.sv */
// Assertion checker for the timer channel pin control block.
`timescale 1ns/1ps
module tcpio_checker #(parameter NCH = 4) (
  // Clock, reset and bus.
  input wire clk,
  input wire nrst,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // Events and pins.
  input wire [NCH-1:0] master_chan_irq,
  input wire [NCH-1:0] slave_chan_irq,
  input wire [NCH-1:0] count_start,
  input wire [NCH-1:0] timer_in_pin,
  input wire [NCH-1:0] in_level,
  input wire [NCH-1:0] in_rise,
  input wire [NCH-1:0] in_fall,
  input wire [NCH-1:0] start_irq,
  input wire [NCH-1:0] chan_start_strobe,
  input wire [NCH-1:0] timer_out_pin
);
  // ****************************************************************
  // Shadow settings
  // ****************************************************************
  // Settings are rebuilt from bus writes, since only ports are visible.
  reg wr_reg, fl_reg;
  reg [11:0] ad_reg;
  reg [NCH-1:0] en_reg, md_reg, pl_reg, si_reg;
  reg [2*NCH-1:0] cm_reg;
  wire [NCH-1:0] hw = hwdata[NCH-1:0];
  wire lw = wr_reg && ad_reg == 12'h000;
  wire [NCH-1:0] tg = en_reg & ~md_reg & slave_chan_irq;
  wire [NCH-1:0] rs = en_reg & md_reg & slave_chan_irq;
  wire [NCH-1:0] st = en_reg & md_reg & master_chan_irq;
  wire [NCH-1:0] ok = ~{cm_reg[7], cm_reg[5], cm_reg[3], cm_reg[1]};
  wire [NCH-1:0] se = count_start & si_reg & ok;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      wr_reg <= 1'b0;
      fl_reg <= 1'b0;
      en_reg <= '0;
      md_reg <= '0;
      pl_reg <= '0;
      si_reg <= '0;
      cm_reg <= '0;
    end
    else
    begin
      wr_reg <= hsel && htrans[1] && hready && hwrite;
      ad_reg <= haddr;
      if (wr_reg)
        case (ad_reg)
          12'h004: en_reg <= hw;
          12'h008: md_reg <= hw;
          12'h00c: pl_reg <= hw;
          12'h018: si_reg <= hw;
          12'h01c: fl_reg <= hwdata[0];
          12'h020: cm_reg <= hwdata[2*NCH-1:0];
          default: ;
        endcase
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_start_strobe: assert property (wr_reg && ad_reg == 12'h010
    |=> chan_start_strobe == $past(hw)) else $error("start strobe");
  a_write_mask: assert property (lw
    |=> ((timer_out_pin ^ $past(hw)) & ~$past(en_reg)) == 0)
    else $error("output write mask");
  a_disabled_hold: assert property (!lw
    |=> ((timer_out_pin ^ $past(timer_out_pin)) & ~$past(en_reg)) == 0)
    else $error("disabled output moved");
  a_master_toggle: assert property (tg != 0 && !lw
    |=> ((timer_out_pin ^ $past(timer_out_pin)) & $past(tg)) == $past(tg))
    else $error("master toggle");
  a_slave_reset: assert property (rs != 0
    |=> ((timer_out_pin ^ $past(pl_reg)) & $past(rs)) == 0)
    else $error("slave reset level");
  a_set_delayed: assert property (st != 0 ##1 slave_chan_irq == 0
    |=> ((timer_out_pin ^ ~$past(pl_reg, 2)) & $past(st, 2)) == 0)
    else $error("delayed set level");
  a_start_irq: assert property (start_irq == $past(se))
    else $error("start interrupt");
  a_sync_only: assert property ((!fl_reg && $stable(timer_in_pin)) [*6]
    |-> in_level == timer_in_pin) else $error("unfiltered level");
  a_filter_lag: assert property (fl_reg && $changed(timer_in_pin)
    |=> $stable(in_level) [*4]) else $error("filter latency");
  a_rise_detect: assert property (in_rise ==
    ($past(in_level) & ~$past(in_level, 2))) else $error("rise edge");
  a_fall_detect: assert property (in_fall ==
    (~$past(in_level) & $past(in_level, 2))) else $error("fall edge");
endmodule
bind tcpio_top tcpio_checker #(.NCH(NCH)) chk_u (.clk, .nrst, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .master_chan_irq,
  .slave_chan_irq, .count_start, .timer_in_pin, .in_level, .in_rise,
  .in_fall, .start_irq,
  .chan_start_strobe, .timer_out_pin);

/* File: test/tcpio_pin_model.sv */
// Model of the signal source that drives the timer input pins.
`timescale 1ns/1ps
module tcpio_pin_model (
  // Clock that times the pin changes.
  input wire clk,
  // Driven input pins.
  output logic [3:0] timer_in_pin
);
  initial timer_in_pin = 4'h0;
  task automatic drive(input logic [3:0] v);
    @(posedge clk);
    timer_in_pin <= v;
  endtask
endmodule

/* File: test/test_timer_channel_pin_io_control.sv */
// Self-checking testbench for the timer channel pin control block.
`timescale 1ns/1ps
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin n_errors++; \
  $display("FAIL %0t got %h exp %h", $time, g, x); end end
module test_timer_channel_pin_io_control;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0;
  logic [11:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0, rd;
  logic [3:0] mi = '0, si = '0, cs = '0, exp;
  wire hready, hreadyout;
  wire [31:0] hrdata;
  wire [3:0] pin, lvl, out, run;
  int n_errors = 0, n_compared = 0;
  always #20 clk = ~clk;
  assign hready = hreadyout;
  tcpio_pin_model pm_u (.clk(clk), .timer_in_pin(pin));
  tcpio_top #(.NCH(4)) dut_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp(), .hrdata,
    .master_chan_irq(mi), .slave_chan_irq(si), .count_start(cs),
    .timer_in_pin(pin), .in_level(lvl), .in_rise(), .in_fall(),
    .start_irq(), .chan_start_strobe(), .chan_running_flag(run),
    .timer_out_pin(out));
  // ****************************************************************
  // Bus and event tasks
  // ****************************************************************
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // The slave never stretches a phase (hreadyout is tied high), yet the wait is bounded, not fixed.
  task automatic wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      n_errors++;
      $display("FAIL %0t bus timeout", $time);
      complete_run;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input logic [11:0] a, input logic [3:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, {28'h0, e})
  endtask
  // The second slave pattern lands on the cycle of the delayed set.
  task automatic ev(input logic [3:0] m, s1, c, s2);
    mi <= m;
    si <= s1;
    cs <= c;
    @(posedge clk);
    mi <= 4'h0;
    si <= s2;
    cs <= 4'h0;
    @(posedge clk);
    si <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a <= 40; a += 4)
      rdc(a[11:0], 4'h0);
    wr(12'h028, 8'hf);
    rdc(12'h028, 4'h0);
    $display("reset values done");
    wr(12'h008, 8'hc);
    wr(12'h00c, 8'h9);
    wr(12'h000, 8'h5);
    wr(12'h004, 8'hf);
    wr(12'h010, 8'hf);
    rdc(12'h014, 4'hf);
    `CHK(run, 4'hf)
    wr(12'h000, 8'ha);
    rdc(12'h000, 4'h5);
    ev(4'h0, 4'h3, 4'h0, 4'h0);
    `CHK(out, 4'h6)
    ev(4'h0, 4'hc, 4'h0, 4'h0);
    `CHK(out, 4'ha)
    ev(4'hc, 4'h0, 4'h0, 4'h0);
    `CHK(out, 4'h6)
    ev(4'hc, 4'h0, 4'h0, 4'hc);
    `CHK(out, 4'ha)
    wr(12'h00c, 8'h0);
    `CHK(out, 4'ha)
    ev(4'h0, 4'hc, 4'h0, 4'h0);
    `CHK(out, 4'h2)
    $display("output modes done");
    wr(12'h004, 8'h0);
    ev(4'hf, 4'hf, 4'hf, 4'h0);
    `CHK(out, 4'h2)
    wr(12'h000, 8'h9);
    rdc(12'h000, 4'h9);
    $display("disabled outputs done");
    wr(12'h008, 8'h0);
    wr(12'h004, 8'hf);
    wr(12'h020, 8'ha4);
    exp = 4'h9;
    for (int i = 0; i < 2; i++)
    begin
      wr(12'h018, i ? 8'h0 : 8'hf);
      ev(4'h0, 4'h0, 4'hf, 4'h0);
      exp = (i == 0) ? exp ^ 4'h3 : exp;
      `CHK(out, exp)
    end
    $display("count start done");
    pm_u.drive(4'h5);
    repeat (8) @(posedge clk);
    `CHK(lvl, 4'h5)
    wr(12'h01c, 8'hf);
    repeat (4) @(posedge clk);
    pm_u.drive(4'ha);
    repeat (4) @(posedge clk);
    `CHK(lvl, 4'h5)
    repeat (6) @(posedge clk);
    `CHK(lvl, 4'ha)
    pm_u.drive(4'hf);
    pm_u.drive(4'ha);
    repeat (10) @(posedge clk);
    `CHK(lvl, 4'ha)
    rdc(12'h024, 4'ha);
    $display("input path done");
    complete_run;
  end
endmodule
